/* pkg/acv_pkg.sv */
// Shared constants and types for the converter control and result block
// Contract
// - Result is ten bits: high byte, two low
// - Result storage read-only, undefined after reset
// - Eight-bit mode: whole result in high byte
// - Ten-bit mode: high byte joined with low bits
// - Straight binary code, k/1024 gives k
// - Out-of-range input saturates at full scale or zero
// - Duration runs from start set to end flag
// - Ten-bit conversion lasts 56 conversion clocks
// - Eight-bit conversion lasts 48 conversion clocks
// - Clock select 00/16, 01/8, 10/1, 11/2
// - Resolution select: 0 eight-bit, 1 ten-bit, resets 0
// - Start bit clears itself when conversion ends
// - Completion sets end flag, irq flag, result
`default_nettype none

package acv_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ACV_AW = 12;                       // Byte address width
  localparam int ACV_RES_W = 10;                    // Result width

  // Register indices; byte address is four times the index
  localparam logic [7:0] ACV_IDX_CTRL = 8'hC8;      // Control and status
  localparam logic [7:0] ACV_IDX_RESH = 8'hC9;      // conversion_result_high
  localparam logic [7:0] ACV_IDX_CFG = 8'hCA;       // conversion_low_and_config
  localparam logic [7:0] ACV_IDX_IST = 8'hCB;       // Interrupt status
  localparam logic [7:0] ACV_IDX_ICLR = 8'hCC;      // Interrupt clear
  localparam logic [7:0] ACV_IDX_IEN = 8'hCD;       // Interrupt enable
  localparam logic [ACV_AW-1:0] ACV_ADDR_CTRL = {2'b00, ACV_IDX_CTRL, 2'b00};
  localparam logic [ACV_AW-1:0] ACV_ADDR_RESH = {2'b00, ACV_IDX_RESH, 2'b00};
  localparam logic [ACV_AW-1:0] ACV_ADDR_CFG = {2'b00, ACV_IDX_CFG, 2'b00};
  localparam logic [ACV_AW-1:0] ACV_ADDR_IST = {2'b00, ACV_IDX_IST, 2'b00};
  localparam logic [ACV_AW-1:0] ACV_ADDR_ICLR = {2'b00, ACV_IDX_ICLR, 2'b00};
  localparam logic [ACV_AW-1:0] ACV_ADDR_IEN = {2'b00, ACV_IDX_IEN, 2'b00};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ACV_CTRL_EN = 7;                   // Converter enable
  localparam int ACV_CTRL_START = 6;                // conversion_start_bit
  localparam int ACV_CTRL_EOC = 5;                  // End of conversion
  localparam int ACV_CFG_CKS1 = 6;                  // Divider select, high
  localparam int ACV_CFG_RES = 5;                   // resolution_select
  localparam int ACV_CFG_CKS0 = 4;                  // Divider select, low
  localparam int ACV_IST_IRQ = 0;                   // conversion_irq_flag

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       ACV_EN_RST = 1'b0;
  localparam logic       ACV_START_RST = 1'b0;
  localparam logic       ACV_EOC_RST = 1'b0;
  localparam logic       ACV_RES_RST = 1'b0;
  localparam logic [1:0] ACV_CKS_RST = 2'h0;
  localparam logic       ACV_IST_RST = 1'b0;
  localparam logic       ACV_IEN_RST = 1'b0;

  // ----------------------------------------------------------------
  // Timing counts, in conversion clocks and instruction clocks
  // ----------------------------------------------------------------
  localparam logic [1:0] ACV_TICKS_PER_SLOT = 2'h3; // Last tick index, 4 per slot
  localparam logic [3:0] ACV_SAMPLE_LAST = 4'h3;    // Four sampling slots
  localparam logic [3:0] ACV_LAST_SLOT_10 = 4'hD;   // 14 slots in ten-bit mode
  localparam logic [3:0] ACV_LAST_SLOT_8 = 4'hB;    // 12 slots in eight-bit mode
  localparam logic [4:0] ACV_DIV_SEL0 = 5'h10;      // Divide by 16
  localparam logic [4:0] ACV_DIV_SEL1 = 5'h08;      // Divide by 8
  localparam logic [4:0] ACV_DIV_SEL2 = 5'h01;      // Divide by 1
  localparam logic [4:0] ACV_DIV_SEL3 = 5'h02;      // Divide by 2
  localparam logic [ACV_RES_W-1:0] ACV_FIRST_BIT = 10'h200;

  // Sequencer states
  typedef enum logic [1:0] {
    ACV_ST_IDLE   = 2'b00,
    ACV_ST_SAMPLE = 2'b01,
    ACV_ST_CONV   = 2'b10
  } acv_state_t;

endpackage

`default_nettype wire

/* pkg/acv_conv_if.sv */
// Link between the sequencer and the approximation register
`timescale 1ns/100ps
`default_nettype none

interface acv_conv_if;
  logic                        load;       // Seed first trial code
  logic                        decide;     // Settle current bit
  logic                        finish;     // Last bit, store result
  logic                        ten_bit;    // Ten-bit resolution
  logic                        cmp_above;  // Input at or above trial
  logic [acv_pkg::ACV_RES_W-1:0] trial;    // Trial code to the DAC
  logic [acv_pkg::ACV_RES_W-1:0] result;   // Stored conversion result

  // Sequencer side
  modport top (output load, decide, finish, ten_bit, cmp_above, input trial, result);
  // Approximation register side
  modport core (input load, decide, finish, ten_bit, cmp_above, output trial, result);
endinterface

`default_nettype wire

/* design/acv_sar_core.sv */
// Successive approximation register and result store
`timescale 1ns/100ps
`default_nettype none

module acv_sar_core (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Sequencer link
  acv_conv_if.core  cif
);
  import acv_pkg::*;

  logic [ACV_RES_W-1:0] trial_q, trial_d;   // Current trial code
  logic [ACV_RES_W-1:0] mask_q, mask_d;     // Bit under test
  logic [ACV_RES_W-1:0] result_q, result_d; // Stored result
  logic [ACV_RES_W-1:0] kept_w;             // Trial after the decision

  // ----------------------------------------------------------------
  // Bit decisions
  // ----------------------------------------------------------------
  always_comb begin
    // MSB first, binary weights; comparator saturates ends
    kept_w = cif.cmp_above ? trial_q : (trial_q & ~mask_q);
    trial_d = trial_q;
    mask_d = mask_q;
    result_d = result_q;
    if (cif.load) begin
      trial_d = ACV_FIRST_BIT;
      mask_d = ACV_FIRST_BIT;
    end else if (cif.decide) begin
      mask_d = mask_q >> 1;
      trial_d = cif.finish ? kept_w : (kept_w | mask_d);
      if (cif.finish) begin
        result_d = cif.ten_bit ? kept_w : {kept_w[ACV_RES_W-1:2], 2'b00};
      end
    end
  end

  // Trial and mask registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trial_q <= '0;
      mask_q <= '0;
    end else begin
      trial_q <= trial_d;
      mask_q <= mask_d;
    end
  end

  always_ff @(posedge clk) begin
    result_q <= result_d;
  end

  assign cif.trial = trial_q;
  assign cif.result = result_q;

endmodule // acv_sar_core

`default_nettype wire

/* design/acv_top.sv */
// Converter control, timing and APB register slave
`timescale 1ns/100ps
`default_nettype none

module acv_top (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [acv_pkg::ACV_AW-1:0]    paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Analog front end
  input  wire logic                          cmp_above,
  output logic      [acv_pkg::ACV_RES_W-1:0] dac_code,
  output logic                               sample_en,
  output logic                               conv_enable,
  // Interrupt
  output logic                               irq
);
  import acv_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------

  // Bus phase and decode
  logic        setup_w;          // Setup phase of a transfer
  logic        access_w;         // Completing access phase
  logic        wr_w;             // Write takes effect this edge
  logic        hit_ctrl;         // Control register hit
  logic        hit_resh;         // Result high byte hit
  logic        hit_cfg;          // Low bits and config hit
  logic        hit_ist;          // Interrupt status hit
  logic        hit_iclr;         // Interrupt clear hit
  logic        hit_ien;          // Interrupt enable hit
  logic        hit_any;          // Any mapped register
  logic [7:0]  rd_byte;          // Read data of the hit register

  // Bus answer registers
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;

  // Software-visible control state
  logic        en_q, en_d;       // Converter enable
  logic        start_q, start_d; // conversion_start_bit
  logic        eoc_q, eoc_d;     // End of conversion
  logic        res_q, res_d;     // resolution_select
  logic [1:0]  cks_q, cks_d;     // conversion_clock_divider_select
  logic        ist_q, ist_d;     // conversion_irq_flag, sticky
  logic        ien_q, ien_d;     // Interrupt enable
  logic        irq_q, irq_d;     // Interrupt output
  logic        go_w;             // Accepted start request

  // Sequencer state
  acv_state_t  state_q, state_d;
  logic [4:0]  div_q, div_d;     // Latched divide ratio
  logic [4:0]  dcnt_q, dcnt_d;   // Instruction clocks within a tick
  logic [1:0]  phase_q, phase_d; // Tick within a slot
  logic [3:0]  slot_q, slot_d;   // Slot within the conversion
  logic        ten_q, ten_d;     // Latched resolution
  logic        samp_q, samp_d;   // Sampling window output
  logic        tick_w;           // Conversion clock tick
  logic        slot_end_w;       // Last tick of a slot
  logic        done_w;           // Conversion completes this edge
  logic        load_w;           // Seed the first trial
  logic        decide_w;         // Settle one bit
  logic [3:0]  last_slot_w;      // Final slot for the resolution

  // Link to the approximation register
  acv_conv_if sar_if ();

  // ----------------------------------------------------------------
  // Divider ratio lookup
  // ----------------------------------------------------------------

  function automatic logic [4:0] div_of(input logic [1:0] sel);
    case (sel)
      2'b00:   div_of = ACV_DIV_SEL0;
      2'b01:   div_of = ACV_DIV_SEL1;
      2'b10:   div_of = ACV_DIV_SEL2;
      2'b11:   div_of = ACV_DIV_SEL3;
      default: div_of = ACV_DIV_SEL0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // APB decode and read mux
  // ----------------------------------------------------------------

  // Phase detection and address decode
  always_comb begin
    setup_w = psel & ~penable;
    access_w = psel & penable & pready_q;
    // Writes need the low byte lane and a mapped address
    wr_w = access_w & pwrite & pstrb[0] & ~pslverr_q;
    hit_ctrl = (paddr == ACV_ADDR_CTRL);
    hit_resh = (paddr == ACV_ADDR_RESH);
    hit_cfg = (paddr == ACV_ADDR_CFG);
    hit_ist = (paddr == ACV_ADDR_IST);
    hit_iclr = (paddr == ACV_ADDR_ICLR);
    hit_ien = (paddr == ACV_ADDR_IEN);
    hit_any = hit_ctrl | hit_resh | hit_cfg | hit_ist | hit_iclr | hit_ien;
  end

  // Read data by register; unused bits read as zero
  always_comb begin
    rd_byte = 8'h00;
    if (hit_ctrl) begin
      rd_byte[ACV_CTRL_EN] = en_q;
      rd_byte[ACV_CTRL_START] = start_q;
      rd_byte[ACV_CTRL_EOC] = eoc_q;
    end else if (hit_resh) begin
      // high byte carries bits 9 to 2
      rd_byte = sar_if.result[ACV_RES_W-1:2];
    end else if (hit_cfg) begin
      rd_byte[ACV_CFG_CKS1] = cks_q[1];
      rd_byte[ACV_CFG_RES] = res_q;
      rd_byte[ACV_CFG_CKS0] = cks_q[0];
      // low result bits in bits 1:0
      rd_byte[1:0] = sar_if.result[1:0];
    end else if (hit_ist) begin
      rd_byte[ACV_IST_IRQ] = ist_q;
    end else if (hit_ien) begin
      rd_byte[ACV_IST_IRQ] = ien_q;
    end
  end

  // Answer: data and status captured in setup, ready in access
  always_comb begin
    prdata_d = prdata_q;
    if (setup_w) begin
      prdata_d = {24'h00_0000, rd_byte};
    end
    pready_d = setup_w;
    // Unmapped addresses answer with an error
    pslverr_d = setup_w & ~hit_any;
  end

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------
  // Control, status and interrupt registers
  // ----------------------------------------------------------------

  // Next control state from writes and conversion events
  always_comb begin
    en_d = en_q;
    start_d = start_q;
    eoc_d = eoc_q;
    res_d = res_q;
    cks_d = cks_q;
    ist_d = ist_q;
    ien_d = ien_q;
    go_w = 1'b0;
    // Control writes; writing zero to the end flag clears it
    if (wr_w && hit_ctrl) begin
      en_d = pwdata[ACV_CTRL_EN];
      if (!pwdata[ACV_CTRL_EOC]) begin
        eoc_d = 1'b0;
      end
      // A start while one runs is ignored
      if (pwdata[ACV_CTRL_START] && pwdata[ACV_CTRL_EN] && !start_q) begin
        go_w = 1'b1;
      end
    end
    if (wr_w && hit_cfg) begin
      res_d = pwdata[ACV_CFG_RES];
      cks_d = {pwdata[ACV_CFG_CKS1], pwdata[ACV_CFG_CKS0]};
    end
    // Write-one clears the sticky flag
    if (wr_w && hit_iclr && pwdata[ACV_IST_IRQ]) begin
      ist_d = 1'b0;
    end
    if (wr_w && hit_ien) begin
      ien_d = pwdata[ACV_IST_IRQ];
    end
    // start bit set opens the measured interval
    if (go_w) begin
      start_d = 1'b1;
      eoc_d = 1'b0;
    end
    // Disabling the converter abandons a conversion
    if (!en_d) begin
      start_d = 1'b0;
    end
    // completion wins over any clear this edge
    if (done_w) begin
      start_d = 1'b0;
      eoc_d = 1'b1;
      ist_d = 1'b1;
    end
    // Level interrupt while an enabled flag is set
    irq_d = ist_d & ien_d;
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= ACV_EN_RST;
      start_q <= ACV_START_RST;
      eoc_q <= ACV_EOC_RST;
      res_q <= ACV_RES_RST;
      cks_q <= ACV_CKS_RST;
      ist_q <= ACV_IST_RST;
      ien_q <= ACV_IEN_RST;
      irq_q <= 1'b0;
    end else begin
      en_q <= en_d;
      start_q <= start_d;
      eoc_q <= eoc_d;
      res_q <= res_d;
      cks_q <= cks_d;
      ist_q <= ist_d;
      ien_q <= ien_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------

  // Slots, ticks and the divided conversion clock
  always_comb begin
    state_d = state_q;
    div_d = div_q;
    dcnt_d = dcnt_q;
    phase_d = phase_q;
    slot_d = slot_q;
    ten_d = ten_q;
    load_w = 1'b0;
    decide_w = 1'b0;
    done_w = 1'b0;
    tick_w = (state_q != ACV_ST_IDLE) && (dcnt_q == div_q - 5'h01);
    slot_end_w = tick_w && (phase_q == ACV_TICKS_PER_SLOT);
    // 14 or 12 slots of four ticks
    last_slot_w = ten_q ? ACV_LAST_SLOT_10 : ACV_LAST_SLOT_8;
    // Advance counters while running
    if (state_q != ACV_ST_IDLE) begin
      dcnt_d = tick_w ? 5'h00 : dcnt_q + 5'h01;
      if (tick_w) begin
        phase_d = phase_q + 2'h1;
      end
      if (slot_end_w) begin
        slot_d = slot_q + 4'h1;
      end
    end
    case (state_q)
      ACV_ST_IDLE: begin
        // Latch timing and resolution at the start
        if (go_w) begin
          state_d = ACV_ST_SAMPLE;
          div_d = div_of(cks_q);
          ten_d = res_q;
          dcnt_d = 5'h00;
          phase_d = 2'h0;
          slot_d = 4'h0;
        end
      end
      ACV_ST_SAMPLE: begin
        // Sampling window, then seed the MSB trial
        if (slot_end_w && slot_q == ACV_SAMPLE_LAST) begin
          state_d = ACV_ST_CONV;
          load_w = 1'b1;
        end
      end
      ACV_ST_CONV: begin
        // One bit settles at the end of each slot
        if (slot_end_w) begin
          decide_w = 1'b1;
          // result stored on the end-flag edge
          if (slot_q == last_slot_w) begin
            done_w = en_q;
            state_d = ACV_ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ACV_ST_IDLE;
      end
    endcase
    // Disable aborts; a start that also sets enable is let through
    if (!en_q && !go_w) begin
      state_d = ACV_ST_IDLE;
      load_w = 1'b0;
      decide_w = 1'b0;
    end
    samp_d = (state_d == ACV_ST_SAMPLE);
  end

  // Sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ACV_ST_IDLE;
      div_q <= ACV_DIV_SEL0;
      dcnt_q <= 5'h00;
      phase_q <= 2'h0;
      slot_q <= 4'h0;
      ten_q <= ACV_RES_RST;
      samp_q <= 1'b0;
    end else begin
      state_q <= state_d;
      div_q <= div_d;
      dcnt_q <= dcnt_d;
      phase_q <= phase_d;
      slot_q <= slot_d;
      ten_q <= ten_d;
      samp_q <= samp_d;
    end
  end

  // ----------------------------------------------------------------
  // Approximation register
  // ----------------------------------------------------------------

  // Strobes and comparator to the register
  assign sar_if.load = load_w;
  assign sar_if.decide = decide_w;
  assign sar_if.finish = done_w;
  assign sar_if.ten_bit = ten_q;
  assign sar_if.cmp_above = cmp_above;

  // Bit decisions and result store
  acv_sar_core u_core (
    .clk   (pclk),
    .rst_n (presetn),
    .cif   (sar_if.core)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // All outputs come from registers
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign dac_code = sar_if.trial;
  assign sample_en = samp_q;
  assign conv_enable = en_q;
  assign irq = irq_q;

endmodule // acv_top

`default_nettype wire

/* sim/acv_chk.sv */
// Port-level property checker for the converter control block
`timescale 1ns/100ps
`default_nettype none

module acv_chk (
  // Clock and reset
  input wire logic                          pclk,
  input wire logic                          presetn,
  // APB slave side
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [31:0]                   prdata,
  input wire logic                          pready,
  // Converter side
  input wire logic [acv_pkg::ACV_RES_W-1:0] dac_code,
  input wire logic                          sample_en,
  input wire logic                          conv_enable,
  input wire logic                          irq
);
  import acv_pkg::*;

  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic        wr_acc;  // Write access phase
  logic [11:0] samp_q;  // Sampling cycles seen
  logic [11:0] samp_d;  // Next sampling count
  assign wr_acc = psel && penable && pwrite;
  // Count cycles while sampling is open
  always_comb samp_d = sample_en ? samp_q + 12'h001 : 12'h000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_q <= 12'h000;
    end else begin
      samp_q <= samp_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  zero_wait_a:
    assert property (psel && !penable |=> pready) else $error("no ready after setup");
  ready_access_a:
    assert property (pready |-> psel && penable) else $error("ready outside access");
  byte_data_a:
    assert property (pready |-> prdata[31:8] == 24'h000000) else $error("upper read bits set");
  irq_clear_a:
    assert property ($fell(irq) |-> $past(wr_acc)) else $error("irq fell without a write");
  enable_write_a:
    assert property ($changed(conv_enable) |-> $past(wr_acc) || $past(wr_acc, 2))
      else $error("enable moved without a write");
  start_write_a:
    assert property ($rose(sample_en) |-> $past(wr_acc) || $past(wr_acc, 2))
      else $error("sampling began without a write");
  sample_len_a:
    assert property ($fell(sample_en) |-> samp_q[3:0] == 4'h0 && samp_q >= 12'h010
      && samp_q <= 12'h100) else $error("sampling length wrong");
  first_trial_a:
    assert property ($fell(sample_en) |-> ##[0:2] dac_code == 10'h200)
      else $error("first trial code wrong");
endmodule // acv_chk

`default_nettype wire

/* sim/test_adc_result_and_timing.sv */
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none

module test_adc_result_and_timing;
  import acv_pkg::*;

  // ----------------------------------------
  // Stimulus and observation
  // ----------------------------------------
  logic                 pclk = 1'b0;
  logic                 presetn = 1'b0;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [ACV_AW-1:0]    paddr = '0;
  logic [31:0]          pwdata = 32'h0;
  logic [3:0]           pstrb = 4'hF;
  logic                 cmp_above = 1'b0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic [ACV_RES_W-1:0] dac_code;
  logic                 sample_en;
  logic                 conv_enable;
  logic                 irq;
  logic [31:0]          rdat;           // Last read data
  logic                 rerr;           // Last error response
  int                   n_errors = 0;
  int                   check_count = 0;
  int                   vin = 0;        // Modelled input, in code steps
  int                   model_q[$];     // Expected results, oldest first

  acv_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_above(cmp_above), .dac_code(dac_code),
    .sample_en(sample_en), .conv_enable(conv_enable), .irq(irq));

  always #5 pclk = ~pclk;
  // Ideal comparator against the trial code
  always @(posedge pclk) cmp_above <= (vin >= int'(dac_code));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled
  task automatic apb(input logic wr, input logic [ACV_AW-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for ready; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [ACV_AW-1:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    check(rdat, exp, what);
  endtask

  // One conversion with its expected code from the model
  task automatic convert(input int res, input int cks, input int v);
    int s, d, n, e, hi;
    s = res ? 14 : 12;
    d = (cks == 0) ? 16 : (cks == 1) ? 8 : (cks == 2) ? 1 : 2;
    vin = v;
    e = (v < 0) ? 0 : (v > 1023) ? 1023 : v;
    if (res == 0) e = e & 32'h3FC;
    model_q.push_back(e);
    apb(1'b1, ACV_ADDR_CFG, {cks[1], res[0], cks[0], 4'h0});
    apb(1'b1, ACV_ADDR_CTRL, 32'hC0);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (irq !== 1'b1 && n < 2000);
    check(n, 4 * s * d, "conversion length");
    rdchk(ACV_ADDR_CTRL, 32'hA0, "start and end bits");
    rdchk(ACV_ADDR_IST, 32'h1, "done flag");
    rdchk(ACV_ADDR_RESH, e >> 2, "result high");
    hi = rdat;
    rdchk(ACV_ADDR_CFG, {cks[1], res[0], cks[0], 2'b00, e[1:0]}, "low bits");
    check((hi * 4 + rdat[1:0]) >> 1, e >> 1, "nine-bit value");
    apb(1'b1, ACV_ADDR_ICLR, 32'h1);
    rdchk(ACV_ADDR_IST, 32'h0, "done cleared");
    $display("done: conversion res %0d select %0d input %0d", res, cks, v);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h95b7));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and bus refusals
    apb(1'b0, ACV_ADDR_CFG, 32'h0);
    check(rdat & 32'h70, 32'h0, "config reset");
    rdchk(ACV_ADDR_CTRL, 32'h0, "control reset");
    apb(1'b0, 12'h000, 32'h0);
    check(rerr, 1'b1, "unmapped error");
    pstrb <= 4'h0;
    apb(1'b1, ACV_ADDR_IEN, 32'h1);
    pstrb <= 4'hF;
    rdchk(ACV_ADDR_IEN, 32'h0, "masked lane write");
    apb(1'b1, ACV_ADDR_IEN, 32'h1);
    $display("done: reset and bus");
    // Every divider select in both resolutions
    for (int i = 0; i < 8; i++) begin
      convert(i / 4, i % 4, (i == 0) ? -5 : (i == 7) ? 1500 : int'($urandom_range(1023, 0)));
    end
    // Result storage ignores writes
    apb(1'b1, ACV_ADDR_RESH, 32'h0);
    rdchk(ACV_ADDR_RESH, model_q[$] >> 2, "result read only");
    // Interrupt masked, then unmasked, then cleared
    apb(1'b1, ACV_ADDR_IEN, 32'h0);
    vin = 300;
    apb(1'b1, ACV_ADDR_CTRL, 32'hC0);
    repeat (120) @(posedge pclk);
    #1;
    check(irq, 1'b0, "masked irq");
    rdchk(ACV_ADDR_IST, 32'h1, "flag while masked");
    rdchk(ACV_ADDR_RESH, 300 >> 2, "masked result");
    apb(1'b1, ACV_ADDR_IEN, 32'h1);
    repeat (2) @(posedge pclk);
    #1;
    check(irq, 1'b1, "unmasked irq");
    apb(1'b1, ACV_ADDR_ICLR, 32'h1);
    repeat (2) @(posedge pclk);
    #1;
    check(irq, 1'b0, "cleared irq");
    $display("done: interrupt");
    // Disabling mid-conversion abandons it with no flag
    apb(1'b1, ACV_ADDR_CTRL, 32'hC0);
    repeat (40) @(posedge pclk);
    apb(1'b1, ACV_ADDR_CTRL, 32'h00);
    repeat (150) @(posedge pclk);
    rdchk(ACV_ADDR_CTRL, 32'h0, "abort clears start");
    rdchk(ACV_ADDR_IST, 32'h0, "no flag on abort");
    $display("done: abort");
    tally_and_finish();
  end

  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    tally_and_finish();
  end
endmodule // test_adc_result_and_timing

bind acv_top acv_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .dac_code(dac_code),
  .sample_en(sample_en), .conv_enable(conv_enable), .irq(irq));

`default_nettype wire
